// File: inc/dac_mode_pkg.sv
package dac_mode_pkg;

    // strap levels as seen on the two strap inputs
    typedef enum logic [1:0]
    {
        MODE_TWO_WIRE = 2'b00,
        MODE_HW_NARROW = 2'b01,
        MODE_HW_WIDE = 2'b10,
        MODE_THREE_WIRE = 2'b11
    } mode_e;

    typedef enum logic [1:0]
    {
        FMT_RJ24 = 2'b00,
        FMT_I2S = 2'b01,
        FMT_LJ = 2'b10,
        FMT_TDM24 = 2'b11
    } fmt_e;

    typedef enum logic [3:0]
    {
        TW_IDLE = 4'h0,
        TW_ADDR = 4'h1,
        TW_ADDR_ACK = 4'h2,
        TW_INDEX = 4'h3,
        TW_INDEX_ACK = 4'h4,
        TW_WDATA = 4'h5,
        TW_WDATA_ACK = 4'h6,
        TW_RDATA = 4'h7,
        TW_RACK = 4'h8
    } tw_state_e;

    typedef struct packed
    {
        logic wide;
        fmt_e format;
        logic deemph;
        logic mute;
    } hw_ctrl_s;

    typedef struct packed
    {
        logic [6:0] index;
        logic [7:0] data;
    } reg_write_s;

    localparam logic [5:0] SLAVE_ADDR_PREFIX = 6'h26;
    localparam logic [6:0] MAX_INDEX = 7'h13;
    localparam logic [4:0] SPI_WORD_BITS = 5'h10;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int SYNC_W = 6;
    localparam hw_ctrl_s HW_CTRL_RESET = '{1'b0, FMT_RJ24, 1'b0, 1'b0};
    localparam reg_write_s REG_WRITE_RESET = '{7'h00, 8'h00};

    function automatic logic index_defined(input logic [6:0] idx);
        index_defined = (idx <= MAX_INDEX);
    endfunction

endpackage

// File: hdl/dac_mode_control_port.sv
`timescale 1ns/1ps
// Contract
// - strap pull-down narrow, pull-up wide oversampling
// - format pins pick one of four formats
// - de-emphasis pin high enables 44.1 kHz
// - mute pin high mutes all channels
// - three-wire port uses own bit clock
// - three-wire active only when strapped, after reset
// - one 16-bit word, msb first
// - write bit, seven index bits, eight data
// - select low, 16 clocks, latch on rise
// - two-wire active only when strapped, after reset
// - slave only, receiver and transmitter
// - address 100110, select pin, then direction
// - answer only own address
// - write: address, index, data, all acknowledged
// - undefined index acknowledged but not written
// - read: index, repeated start, one byte, nack
// - strap captured once after power-on reset
module dac_mode_control_port
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_strap_i,
    input wire logic format_select_low_i,
    input wire logic pin_select_i,
    input wire logic pin_clock_i,
    input wire logic pin_data_i,
    output logic pin_data_o,
    output logic pin_data_oe_o,
    input wire logic [7:0] reg_read_data_i,
    output dac_mode_pkg::mode_e mode_o,
    output logic mode_valid_o,
    output dac_mode_pkg::hw_ctrl_s hw_ctrl_o,
    output logic reg_write_valid_o,
    output dac_mode_pkg::reg_write_s reg_write_o,
    output logic [6:0] reg_index_o
);
    import dac_mode_pkg::*;

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [2:0] hist;
    logic [1:0] settle;
    logic sel;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    logic sel_rise;
    logic sel_fall;
    logic spi_on;
    logic tw_on;

    // every pin passes two flops before use
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1 <= '0;
            sync2 <= '0;
            hist <= 3'h7;
        end
        else
        begin
            sync1 <= {mode_strap_i, format_select_low_i, pin_select_i, pin_clock_i, pin_data_i};
            sync2 <= sync1;
            hist <= sync2[2:0];
        end
    end

    assign sel = sync2[2];
    assign scl = sync2[1];
    assign sda = sync2[0];
    assign sel_rise = sel & ~hist[2];
    assign sel_fall = ~sel & hist[2];
    assign scl_rise = scl & ~hist[1];
    assign scl_fall = ~scl & hist[1];
    assign sda_rise = sda & ~hist[0];
    assign sda_fall = ~sda & hist[0];

    // strap taken once, later changes ignored until next reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            settle <= '0;
            mode_valid_o <= 1'b0;
            mode_o <= MODE_TWO_WIRE;
        end
        else if (!mode_valid_o)
        begin
            settle <= settle + 2'h1;
            if (settle == STRAP_SETTLE)
            begin
                mode_valid_o <= 1'b1;
                mode_o <= mode_e'(sync2[5:4]);
            end
        end
    end

    assign spi_on = mode_valid_o && (mode_o == MODE_THREE_WIRE);
    assign tw_on = mode_valid_o && (mode_o == MODE_TWO_WIRE);

    // parallel pin control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hw_ctrl_o <= HW_CTRL_RESET;
        end
        else if (mode_valid_o && (mode_o == MODE_HW_NARROW || mode_o == MODE_HW_WIDE))
        begin
            hw_ctrl_o.wide <= (mode_o == MODE_HW_WIDE);
            hw_ctrl_o.format <= fmt_e'({sel, sync2[3]});
            hw_ctrl_o.deemph <= scl;
            hw_ctrl_o.mute <= sda;
        end
        else
        begin
            hw_ctrl_o <= HW_CTRL_RESET;
        end
    end

    // three-wire port
    logic [15:0] spi_shift;
    logic [4:0] spi_count;
    logic spi_write;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            spi_shift <= '0;
            spi_count <= '0;
        end
        else if (spi_on)
        begin
            if (sel_fall)
            begin
                spi_count <= '0;
            end
            else if (!sel && scl_rise)
            begin
                spi_shift <= {spi_shift[14:0], sda};
                if (spi_count <= SPI_WORD_BITS)
                begin
                    spi_count <= spi_count + 5'h1;
                end
            end
        end
    end

    // exactly sixteen bits with a leading zero make a write
    assign spi_write = spi_on && sel_rise && (spi_count == SPI_WORD_BITS)
        && !spi_shift[15];

    // two-wire slave
    tw_state_e tw_state;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [3:0] bits;
    logic rw;
    logic tw_write;
    logic addr_match;

    assign addr_match = (rx[7:1] == {SLAVE_ADDR_PREFIX, sel});
    assign tw_write = tw_on && scl_fall && (tw_state == TW_WDATA) && (bits == BYTE_BITS)
        && index_defined(reg_index_o);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tw_state <= TW_IDLE;
            rx <= '0;
            tx <= '0;
            bits <= '0;
            rw <= 1'b0;
            pin_data_oe_o <= 1'b0;
            reg_index_o <= '0;
        end
        else if (!tw_on)
        begin
            tw_state <= TW_IDLE;
            pin_data_oe_o <= 1'b0;
            if (spi_write)
            begin
                reg_index_o <= spi_shift[14:8];
            end
        end
        else if (scl && sda_fall)
        begin
            tw_state <= TW_ADDR; // start or repeated start
            bits <= '0;
            pin_data_oe_o <= 1'b0;
        end
        else if (scl && sda_rise)
        begin
            tw_state <= TW_IDLE;
            pin_data_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (tw_state)
                TW_ADDR, TW_INDEX, TW_WDATA:
                begin
                    rx <= {rx[6:0], sda};
                    bits <= bits + 4'h1;
                end
                TW_RDATA:
                begin
                    bits <= bits + 4'h1;
                end
                TW_RACK:
                begin
                    tw_state <= TW_IDLE; // single byte read
                end
                TW_IDLE, TW_ADDR_ACK, TW_INDEX_ACK, TW_WDATA_ACK:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (tw_state)
                TW_ADDR:
                begin
                    if (bits == BYTE_BITS)
                    begin
                        if (addr_match)
                        begin
                            tw_state <= TW_ADDR_ACK;
                            rw <= rx[0];
                            pin_data_oe_o <= 1'b1;
                        end
                        else
                        begin
                            tw_state <= TW_IDLE;
                        end
                    end
                end
                TW_ADDR_ACK:
                begin
                    bits <= '0;
                    if (rw)
                    begin
                        tw_state <= TW_RDATA;
                        tx <= {reg_read_data_i[6:0], 1'b0};
                        pin_data_oe_o <= ~reg_read_data_i[7];
                    end
                    else
                    begin
                        tw_state <= TW_INDEX;
                        pin_data_oe_o <= 1'b0;
                    end
                end
                TW_INDEX:
                begin
                    if (bits == BYTE_BITS)
                    begin
                        tw_state <= TW_INDEX_ACK;
                        reg_index_o <= rx[6:0];
                        pin_data_oe_o <= 1'b1;
                    end
                end
                TW_INDEX_ACK:
                begin
                    tw_state <= TW_WDATA;
                    bits <= '0;
                    pin_data_oe_o <= 1'b0;
                end
                TW_WDATA:
                begin
                    if (bits == BYTE_BITS)
                    begin
                        tw_state <= TW_WDATA_ACK;
                        pin_data_oe_o <= 1'b1;
                    end
                end
                TW_RDATA:
                begin
                    if (bits == BYTE_BITS)
                    begin
                        tw_state <= TW_RACK;
                        pin_data_oe_o <= 1'b0;
                    end
                    else
                    begin
                        tx <= {tx[6:0], 1'b0};
                        pin_data_oe_o <= ~tx[7];
                    end
                end
                TW_WDATA_ACK, TW_RACK:
                begin
                    tw_state <= TW_IDLE;
                    pin_data_oe_o <= 1'b0;
                end
                TW_IDLE:
                begin
                end
            endcase
        end
    end

    // open-drain: only ever pulls low, never starts a transfer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_data_o <= 1'b0;
        end
        else
        begin
            pin_data_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_write_valid_o <= 1'b0;
            reg_write_o <= REG_WRITE_RESET;
        end
        else
        begin
            reg_write_valid_o <= spi_write || tw_write;
            if (spi_write)
            begin
                reg_write_o <= '{spi_shift[14:8], spi_shift[7:0]};
            end
            else if (tw_write)
            begin
                reg_write_o <= '{reg_index_o, rx};
            end
        end
    end

endmodule

// File: bench/dac_mode_control_port_assertions.sv
`timescale 1ns/1ps
module dac_mode_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic format_select_low_i,
    input wire logic pin_select_i,
    input wire logic pin_clock_i,
    input wire logic pin_data_i,
    input wire logic pin_data_o,
    input wire logic pin_data_oe_o,
    input wire dac_mode_pkg::mode_e mode_o,
    input wire logic mode_valid_o,
    input wire dac_mode_pkg::hw_ctrl_s hw_ctrl_o,
    input wire logic reg_write_valid_o,
    input wire dac_mode_pkg::reg_write_s reg_write_o
);
    import dac_mode_pkg::*;
    logic [3:0] pins_q;
    logic [2:0] quiet;
    wire [3:0] pins = {pin_select_i, format_select_low_i, pin_clock_i, pin_data_i};
    wire hw = mode_valid_o && (mode_o == MODE_HW_NARROW || mode_o == MODE_HW_WIDE);
    wire settled = hw && quiet == 3'h7;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since the pins last moved, so a sync latency of up to seven cycles is tolerated
    always_ff @(posedge clk_i)
    begin
        pins_q <= pins;
        if (rst_i || pins != pins_q)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    property p_wide;
        settled |-> hw_ctrl_o.wide == mode_o[1];
    endproperty
    a_wide: assert property (p_wide)
        else $error("oversampling width wrong");
    property p_fmt;
        settled |-> hw_ctrl_o.format == pins_q[3:2];
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("format wrong");
    property p_dm;
        settled |-> {hw_ctrl_o.deemph, hw_ctrl_o.mute} == pins_q[1:0];
    endproperty
    a_dm: assert property (p_dm)
        else $error("de-emphasis or mute wrong");
    property p_mode;
        mode_valid_o |=> mode_valid_o && $stable(mode_o);
    endproperty
    a_mode: assert property (p_mode)
        else $error("captured mode moved");
    property p_latch;
        reg_write_valid_o && mode_o == MODE_THREE_WIRE
            |-> pin_select_i && $past(pin_select_i, 2) && !$past(pin_select_i, 7);
    endproperty
    a_latch: assert property (p_latch)
        else $error("write not tied to select rise");
    property p_oe;
        pin_data_oe_o |-> !pin_data_o && mode_valid_o && mode_o == MODE_TWO_WIRE;
    endproperty
    a_oe: assert property (p_oe)
        else $error("data pin driven outside two-wire");
    property p_wr_only;
        $changed(reg_write_o) |-> reg_write_valid_o;
    endproperty
    a_wr_only: assert property (p_wr_only)
        else $error("write bus moved without pulse");
    property p_wr_mode;
        reg_write_valid_o |-> mode_valid_o && !hw;
    endproperty
    a_wr_mode: assert property (p_wr_mode)
        else $error("write in wrong mode");
endmodule

// File: bench/serial_host.sv
`timescale 1ns/1ps
module serial_host
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic sel_o,
    output logic fsl_o,
    output logic scl_o,
    output logic sda_o
);
    initial {sel_o, fsl_o, scl_o, sda_o} = 4'hF;
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pins(input logic [3:0] p);
        {sel_o, fsl_o, scl_o, sda_o} <= p;
        w(10);
    endtask
    // one 160 ns link clock, line sampled while high
    task automatic bit_(input logic b, output logic s);
        sda_o <= b;
        w(4);
        scl_o <= 1'b1;
        w(4);
        s = sda_i;
        w(4);
        scl_o <= 1'b0;
        w(4);
    endtask
    task automatic spi(input logic [15:0] d, input int n);
        logic s;
        scl_o <= 1'b0;
        w(4);
        sel_o <= 1'b0;
        w(4);
        for (int i = 15; i > 15 - n; i--)
            bit_(d[i], s);
        sel_o <= 1'b1;
        sda_o <= ~sda_o;
        w(8);
    endtask
    task automatic start();
        sda_o <= 1'b1;
        w(4);
        scl_o <= 1'b1;
        w(4);
        sda_o <= 1'b0;
        w(4);
        scl_o <= 1'b0;
        w(4);
    endtask
    task automatic stop();
        sda_o <= 1'b0;
        w(4);
        scl_o <= 1'b1;
        w(4);
        sda_o <= 1'b1;
        w(8);
    endtask
    // ninth bit released: ack from slave, or nack after a read
    task automatic byte_(input logic [7:0] b, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_(b[i], r[i]);
        bit_(1'b1, a);
        a = ~a;
    endtask
endmodule

// File: bench/dac_mode_control_port_tb.sv
`timescale 1ns/1ps
module dac_mode_control_port_tb;
    import dac_mode_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap = 2'h1;
    logic sel, fsl, scl, sda_m, sda, oe, dout, wv, mv;
    mode_e mode;
    hw_ctrl_s hw;
    reg_write_s wr;
    logic [6:0] idx;
    logic [7:0] rdat;
    int error_cnt = 0;
    int num_checks = 0;
    int wcnt = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    assign sda = sda_m & ~oe;
    assign rdat = {1'b0, idx} ^ 8'h5A;
    dac_mode_control_port uut
    (
        .clk_i(clk), .rst_i(rst), .mode_strap_i(strap), .format_select_low_i(fsl),
        .pin_select_i(sel), .pin_clock_i(scl), .pin_data_i(sda), .pin_data_o(dout),
        .pin_data_oe_o(oe), .reg_read_data_i(rdat), .mode_o(mode), .mode_valid_o(mv),
        .hw_ctrl_o(hw), .reg_write_valid_o(wv), .reg_write_o(wr), .reg_index_o(idx)
    );
    serial_host host
    (
        .clk_i(clk), .sda_i(sda), .sel_o(sel), .fsl_o(fsl), .scl_o(scl), .sda_o(sda_m)
    );
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wv === 1'b1)
            wcnt <= wcnt + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic boot(input logic [1:0] s);
        rst <= 1'b1;
        strap <= s;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        chk(mv === 1'b1 && mode === mode_e'(s), "mode capture");
    endtask
    task automatic t_hw(input logic [1:0] s);
        boot(s);
        for (int i = 0; i < 16; i++)
        begin
            host.pins(i[3:0]);
            chk(hw === {s[1], i[3:0]}, "pin control");
        end
        strap <= ~s;
        host.pins(4'h5);
        chk(hw === {s[1], 4'h5} && mode === mode_e'(s), "strap ignored");
    endtask
    task automatic t_spi();
        int n;
        host.pins(4'h8);
        boot(2'h3);
        n = wcnt;
        host.spi(16'h4DC3, 16);
        chk(wcnt == n + 1 && wr === {7'h4D, 8'hC3}, "spi write");
        host.spi(16'h0155, 15);
        chk(wcnt == n + 1, "short word");
        host.spi(16'h8155, 16);
        chk(wcnt == n + 1, "msb set");
        strap <= 2'h0;
        host.spi(16'h0155, 16);
        host.spi(16'h02AA, 16);
        chk(wcnt == n + 3 && wr === {7'h02, 8'hAA}, "back to back");
    endtask
    task automatic tw_wr(input logic [7:0] ad, ix, d, output logic [2:0] ak);
        logic [7:0] r;
        host.start();
        host.byte_(ad, r, ak[2]);
        host.byte_(ix, r, ak[1]);
        host.byte_(d, r, ak[0]);
        host.stop();
    endtask
    task automatic t_tw();
        logic [2:0] ak;
        logic [7:0] r;
        int n;
        host.pins(4'hB);
        boot(2'h0);
        n = wcnt;
        host.spi(16'h0155, 16);
        host.pins(4'hB);
        chk(wcnt == n, "three-wire word outside its mode");
        tw_wr(8'h9A, 8'h05, 8'h3C, ak);
        chk(ak === 3'h7 && wr === {7'h05, 8'h3C}, "tw write");
        tw_wr(8'h9A, 8'h13, 8'hA5, ak);
        chk(ak === 3'h7 && wr === {7'h13, 8'hA5}, "last index");
        tw_wr(8'h9A, 8'h14, 8'h77, ak);
        chk(ak === 3'h7 && wcnt == n + 2, "undefined index");
        tw_wr(8'h98, 8'h05, 8'h11, ak);
        chk(ak[2] === 1'b0 && wcnt == n + 2, "foreign address");
        host.start();
        host.byte_(8'h9A, r, ak[2]);
        host.byte_(8'h07, r, ak[1]);
        host.start();
        host.byte_(8'h9B, r, ak[0]);
        host.byte_(8'hFF, r, ak[0]);
        host.stop();
        chk(ak[2:1] === 2'h3 && r === 8'h5D && dout === 1'b0, "tw read");
    endtask
    initial
    begin
        t_hw(2'h1);
        t_hw(2'h2);
        t_spi();
        t_tw();
        finish_test();
    end
endmodule
bind dac_mode_control_port dac_mode_chk chk_inst
(
    .clk_i(clk_i), .rst_i(rst_i), .format_select_low_i(format_select_low_i),
    .pin_select_i(pin_select_i), .pin_clock_i(pin_clock_i), .pin_data_i(pin_data_i),
    .pin_data_o(pin_data_o), .pin_data_oe_o(pin_data_oe_o), .mode_o(mode_o),
    .mode_valid_o(mode_valid_o), .hw_ctrl_o(hw_ctrl_o),
    .reg_write_valid_o(reg_write_valid_o), .reg_write_o(reg_write_o)
);
